// >>> analog_status_revision_regs.sv
// Monitor status and silicon identification registers behind an APB slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "monitor_map.svh"

// Behaviour
// - Read-only monitor status at index 0x03
// - Status reads zero after reset
// - Bit 6 shows twenty-volt rail good
// - Bit 5 shows second converter good
// - Bit 4 shows bus voltage good
// - Bit 3 shows filter capacitor good
// - Bit 2 shows crystal running
// - Bit 1 shows thermal warning present
// - Bit 0 records a past thermal shutdown
// - Bit 7 reserved, no function, reads zero
// - Identification at 0x05: revision, part number
module analog_status_revision_regs #(
  parameter logic [4:0] PART_NUMBER = 5'h12,     // Arbitrary value
  parameter logic [2:0] SILICON_REVISION = 3'h1  // Arbitrary value
) (
  // Clock, reset, enable
  input logic sys_clk,
  input logic sys_rst,
  input logic clk_en,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitor inputs, high while good or active
  input logic twenty_volt_rail_ok,
  input logic second_converter_ok,
  input logic bus_voltage_ok,
  input logic filter_capacitor_ok,
  input logic xtal_running,
  input logic thermal_warning,
  input logic thermal_shutdown_trip,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Bundled bus request
  monitor_pkg::apb_req_type req;
  // Raw and registered monitor words
  monitor_pkg::monitor_status_type raw_status;
  monitor_pkg::monitor_status_type status_view;
  // Identification word
  monitor_pkg::silicon_id_type ident;
  // Sampler outputs
  logic [7:0] status_bits;
  logic [7:0] status_change;
  // Shutdown record
  logic shut_seen_q;
  // Interrupt state
  logic [7:0] irq_flags;
  logic [7:0] irq_mask_q;
  logic [7:0] irq_mask_d;
  logic [7:0] irq_clear;
  logic irq_q;
  // Slave phase and answer registers
  monitor_pkg::apb_phase_type phase_q;
  monitor_pkg::apb_phase_type phase_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  ////////////////////////////////////////////////////////////////////////////
  // Request bundling and decode

  // Pack the bus into one struct
  assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr,
                 wdata: pwdata, strb: pstrb};

  // Setup phase seen while idle
  wire logic setup_seen = req.sel & ~req.enable & (phase_q == monitor_pkg::APB_IDLE);
  // Completing access edge
  wire logic access_done = req.sel & req.enable & pready_q;
  // Write that takes effect at this edge
  wire logic wr_fire = access_done & req.write & clk_en;

  // Address hits, one aligned word per register
  wire logic hit_status = (req.addr == {`STATUS_INDEX, 2'b00});
  wire logic hit_ident = (req.addr == {`IDENT_INDEX, 2'b00});
  wire logic hit_irq_status = (req.addr == {`IRQ_STATUS_INDEX, 2'b00});
  wire logic hit_irq_mask = (req.addr == {`IRQ_MASK_INDEX, 2'b00});
  // Anything else answers with an error
  wire logic unmapped = ~(hit_status | hit_ident | hit_irq_status | hit_irq_mask);
  // Low byte lane enabled
  wire logic lane0 = req.strb[0];

  ////////////////////////////////////////////////////////////////////////////
  // Monitor capture

  // Shutdown record: held until reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shut_seen_q <= 1'b0;
    end else if (clk_en) begin
      shut_seen_q <= shut_seen_q | thermal_shutdown_trip;
    end
  end

  // Gather raw monitor levels
  assign raw_status.reserved = 1'b0;
  assign raw_status.twenty_volt_rail_ok = twenty_volt_rail_ok;
  assign raw_status.second_converter_ok = second_converter_ok;
  assign raw_status.bus_voltage_ok = bus_voltage_ok;
  assign raw_status.filter_capacitor_ok = filter_capacitor_ok;
  assign raw_status.xtal_running = xtal_running;
  assign raw_status.thermal_warning = thermal_warning;
  assign raw_status.thermal_shutdown_seen = shut_seen_q;

  // Register every monitor level, zero from reset
  monitor_sampler #(
    .WIDTH(8)
  ) u_sampler (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .raw(raw_status),
    .level_q(status_bits),
    .change_q(status_change)
  );

  // Typed view of the status word
  assign status_view = status_bits;

  // Fixed identification word
  assign ident = '{revision: SILICON_REVISION, part_number: PART_NUMBER};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags and mask

  // Write one to clear, low byte only
  assign irq_clear = (wr_fire & hit_irq_status & lane0) ? req.wdata[7:0] : 8'h00;

  // Any monitor change is an event
  event_flags #(
    .WIDTH(8)
  ) u_flags (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .set(status_change & `LIVE_MASK),
    .clear(irq_clear),
    .flags_q(irq_flags)
  );

  // Mask takes a write to its own word only
  assign irq_mask_d = (wr_fire & hit_irq_mask & lane0) ?
                      (req.wdata[7:0] & `LIVE_MASK) : irq_mask_q;

  // Any unmasked flag pending
  wire logic irq_any = |(irq_flags & irq_mask_q);

  // Mask and interrupt line registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_mask_q <= `IRQ_MASK_RESET;
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read selection

  // Read mux; writes to read-only words change nothing
  wire logic [7:0] rd_byte = hit_status ? status_bits :
                             hit_ident ? ident :
                             hit_irq_status ? irq_flags :
                             hit_irq_mask ? irq_mask_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Slave phase control

  // Answer one cycle after setup, drop after completion
  always_comb begin
    phase_d = phase_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    unique case (phase_q)
      // Wait for a setup phase
      monitor_pkg::APB_IDLE: begin
        if (setup_seen) begin
          phase_d = monitor_pkg::APB_ANSWER;
          pready_d = 1'b1;
          pslverr_d = unmapped;
          // Read-only words give no error on write
          prdata_d = (req.write | unmapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
      end
      // Access completes at this edge
      monitor_pkg::APB_ANSWER: begin
        phase_d = monitor_pkg::APB_IDLE;
      end
      // Illegal codes recover to idle
      default: begin
        phase_d = monitor_pkg::APB_IDLE;
      end
    endcase
  end

  // Phase and answer registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_q <= monitor_pkg::APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      phase_q <= phase_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Enabled setup phase
  sequence s_setup;
    psel && !penable && (phase_q == monitor_pkg::APB_IDLE) && clk_en;
  endsequence

  // Enabled read setup to the status word
  sequence s_status_read;
    s_setup ##0 !pwrite && hit_status;
  endsequence

  // Enabled read setup to the identification word
  sequence s_ident_read;
    s_setup ##0 !pwrite && hit_ident;
  endsequence

  // Enabled write setup to a read-only word
  sequence s_ro_write;
    s_setup ##0 pwrite && (hit_status || hit_ident);
  endsequence

  // Status read returns the registered status byte
  a_status_read_data: assert property (
    s_status_read |=> pready && !pslverr && prdata == {24'h00_0000, $past(status_bits)})
    else $error("status read data wrong");

  // Status is zero right after reset
  a_status_reset_zero: assert property (
    @(posedge sys_clk) disable iff (1'b0) sys_rst |=> status_bits == `STATUS_RESET)
    else $error("status not zero after reset");

  // Bits 6 to 1 each follow their monitor one enabled edge later
  a_twenty_volt_follow: assert property (
    clk_en |=> status_view.twenty_volt_rail_ok == $past(twenty_volt_rail_ok))
    else $error("twenty volt flag wrong");
  a_second_conv_follow: assert property (
    clk_en |=> status_view.second_converter_ok == $past(second_converter_ok))
    else $error("second converter flag wrong");
  a_bus_voltage_follow: assert property (
    clk_en |=> status_view.bus_voltage_ok == $past(bus_voltage_ok))
    else $error("bus voltage flag wrong");
  a_filter_cap_follow: assert property (
    clk_en |=> status_view.filter_capacitor_ok == $past(filter_capacitor_ok))
    else $error("filter capacitor flag wrong");
  a_xtal_follow: assert property (
    clk_en |=> status_view.xtal_running == $past(xtal_running))
    else $error("crystal flag wrong");
  a_thermal_warn_follow: assert property (
    clk_en |=> status_view.thermal_warning == $past(thermal_warning))
    else $error("thermal warning flag wrong");

  // Shutdown trip shows after two enabled edges and is still set one cycle later
  a_shutdown_recorded: assert property (
    (thermal_shutdown_trip && clk_en) ##1 clk_en |=> status_view.thermal_shutdown_seen [*2])
    else $error("shutdown record missing");

  // Reserved bit never reads one
  a_reserved_zero: assert property (
    pready && hit_status |-> !prdata[`RESERVED_BIT] && !status_view.reserved)
    else $error("reserved bit set");

  // Identification read returns revision and part number
  a_ident_read_data: assert property (
    s_ident_read |=> pready && prdata == {24'h00_0000, SILICON_REVISION, PART_NUMBER})
    else $error("identification read wrong");

  // Write to a read-only word: no error, no data, interrupt mask untouched
  a_ro_write_ignored: assert property (
    s_ro_write |=> pready && !pslverr && prdata == 32'h0000_0000 &&
                   irq_mask_q == $past(irq_mask_q))
    else $error("read-only write had an effect");

  // Interrupt line tracks masked flags
  a_irq_level: assert property (
    clk_en |=> irq == $past(irq_any))
    else $error("interrupt level wrong");

endmodule

// >>> monitor_map.svh
// Register map constants for the monitor status and identification block
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

// Register indices; byte address is four times the index
`define STATUS_INDEX 10'h003
`define IDENT_INDEX 10'h005
`define IRQ_STATUS_INDEX 10'h006
`define IRQ_MASK_INDEX 10'h007

// Reset values
`define STATUS_RESET 8'h00
`define IRQ_STATUS_RESET 8'h00
`define IRQ_MASK_RESET 8'h00

// Monitor status field positions
`define RESERVED_BIT 7
`define TWENTY_VOLT_BIT 6
`define SECOND_CONV_BIT 5
`define BUS_VOLTAGE_BIT 4
`define FILTER_CAP_BIT 3
`define XTAL_BIT 2
`define THERMAL_WARN_BIT 1
`define THERMAL_SHUT_BIT 0

// Identification field positions
`define REV_MSB 7
`define REV_LSB 5
`define PART_MSB 4
`define PART_LSB 0

// Bits that can raise an event (reserved bit excluded)
`define LIVE_MASK 8'h7f

`endif

// >>> monitor_pkg.sv
// Types shared by the monitor status and identification block
package monitor_pkg;

  // Monitor status word, one flag per monitor
  typedef struct packed {
    logic reserved;
    logic twenty_volt_rail_ok;
    logic second_converter_ok;
    logic bus_voltage_ok;
    logic filter_capacitor_ok;
    logic xtal_running;
    logic thermal_warning;
    logic thermal_shutdown_seen;
  } monitor_status_type;

  // Identification word
  typedef struct packed {
    logic [2:0] revision;
    logic [4:0] part_number;
  } silicon_id_type;

  // One APB request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] strb;
  } apb_req_type;

  // Slave phase
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_ANSWER = 2'b01
  } apb_phase_type;

endpackage

// >>> monitor_sampler.sv
// Per-bit monitor level register with change pulse
`timescale 1ns/100ps
module monitor_sampler #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input logic sys_clk,
  input logic sys_rst,
  input logic clk_en,
  // Raw monitor levels
  input logic [WIDTH-1:0] raw,
  // Registered levels and change pulses
  output logic [WIDTH-1:0] level_q,
  output logic [WIDTH-1:0] change_q
);

  ////////////////////////////////////////////////////////////////////////////
  // One flop pair per monitor bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Level follows input; change pulses when it moves
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          level_q[i] <= 1'b0;
          change_q[i] <= 1'b0;
        end else if (clk_en) begin
          level_q[i] <= raw[i];
          change_q[i] <= raw[i] ^ level_q[i];
        end
      end
    end
  endgenerate

endmodule

// >>> event_flags.sv
// Sticky event flags, write one to clear, set wins over clear
`timescale 1ns/100ps
module event_flags #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input logic sys_clk,
  input logic sys_rst,
  input logic clk_en,
  // Event set and software clear
  input logic [WIDTH-1:0] set,
  input logic [WIDTH-1:0] clear,
  // Flag state
  output logic [WIDTH-1:0] flags_q
);

  ////////////////////////////////////////////////////////////////////////////
  // One sticky flop per event bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      // A new event in the clearing cycle survives
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          flags_q[i] <= 1'b0;
        end else if (clk_en) begin
          flags_q[i] <= set[i] | (flags_q[i] & ~clear[i]);
        end
      end
    end
  endgenerate

endmodule

// >>> apb_host_model.sv
// Host controller model: APB master that reads and writes the monitor registers
`timescale 1ns/100ps
module apb_host_model (
  // Clock
  input wire logic sys_clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One transfer: setup, access held until pready, answer taken at that edge
  // Bit 7 of status is never acted on; part number is handed back for checking
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait for the answer; the bench timeout cuts a hang
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Released lines show inverted values, never the stale ones
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// >>> analog_status_revision_regs_tb.sv
// Self-checking bench for the monitor status and identification registers
`timescale 1ns/100ps
`include "monitor_map.svh"
module analog_status_revision_regs_tb;
  localparam logic [4:0] PART = 5'h0b; // Arbitrary value
  localparam logic [2:0] REV = 3'h5;   // Arbitrary value
  // Byte addresses, four times the index
  localparam logic [11:0] A_STAT = {`STATUS_INDEX, 2'b00};
  localparam logic [11:0] A_ID = {`IDENT_INDEX, 2'b00};
  localparam logic [11:0] A_IST = {`IRQ_STATUS_INDEX, 2'b00};
  localparam logic [11:0] A_MSK = {`IRQ_MASK_INDEX, 2'b00};
  localparam logic [11:0] A_BAD = 12'h100;
  // Clock, reset and design signals
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0] pstrb;
  logic [6:1] mon = 6'h00;  // Monitor levels, bit n feeds status bit n
  logic trip = 1'b0;        // Thermal shutdown event
  logic er;
  logic [32:0] ev;          // Expected answer of a random read
  // Expected answers {pslverr, prdata}, oldest first
  logic [32:0] exp_q[$];
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  integer seed = 17015;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Design and host model
  analog_status_revision_regs #(.PART_NUMBER(PART), .SILICON_REVISION(REV)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .twenty_volt_rail_ok(mon[6]), .second_converter_ok(mon[5]),
    .bus_voltage_ok(mon[4]), .filter_capacitor_ok(mon[3]), .xtal_running(mon[2]),
    .thermal_warning(mon[1]), .thermal_shutdown_trip(trip), .irq(irq));
  apb_host_model host (
    .sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Mismatch report
  task automatic mism(input string m);
    n_errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask

  // Compare one answer against its note
  task automatic cmp_rd(input logic [32:0] e);
    n_tests++;
    if ({pslverr, prdata} !== e) begin
      mism($sformatf("answer %h expected %h", {pslverr, prdata}, e));
    end
  endtask

  // Compare the interrupt line
  task automatic cmp_irq(input logic e);
    n_tests++;
    if (irq !== e) begin
      mism($sformatf("irq %b expected %b", irq, e));
    end
  endtask

  // Note the expected answer, then run the transfer
  task automatic xact(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
    exp_q.push_back(e);
    host.xfer(w, a, d, rd, er);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watcher: each completing access takes the oldest note
  always @(posedge sys_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0)
        mism("answer without a pending note");
      else
        cmp_rd(exp_q.pop_front());
    end
  end

  // Timeout on a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mism("timeout");
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values and identification
    xact(1'b0, A_STAT, 32'h0, 33'h0);
    xact(1'b0, A_ID, 32'h0, {25'h0, REV, PART});
    cmp_irq(1'b0);
    // One monitor at a time
    for (int b = 1; b <= 6; b++) begin
      mon <= 6'(1 << (b - 1));
      repeat (2) @(posedge sys_clk);
      xact(1'b0, A_STAT, 32'h0, {25'h0, 8'(1 << b)});
    end
    // One-cycle shutdown event is recorded
    trip <= 1'b1;
    @(posedge sys_clk);
    trip <= 1'b0;
    repeat (3) @(posedge sys_clk);
    xact(1'b0, A_STAT, 32'h0, {25'h0, 8'h41});
    // Random levels; record stays, reserved bit stays low
    repeat (8) begin
      v = $random(seed);
      mon <= v[5:0];
      repeat (2) @(posedge sys_clk);
      ev = {26'h0, v[5:0], 1'b1};
      xact(1'b0, A_STAT, 32'h0, ev);
    end
    // Writes to read-only places change nothing
    xact(1'b1, A_STAT, 32'hffff_ffff, 33'h0);
    xact(1'b1, A_ID, 32'h0000_0000, 33'h0);
    xact(1'b0, A_STAT, 32'h0, {26'h0, v[5:0], 1'b1});
    xact(1'b0, A_ID, 32'h0, {25'h0, REV, PART});
    // Unmapped and misaligned addresses are refused
    xact(1'b0, A_BAD, 32'h0, {1'b1, 32'h0});
    xact(1'b0, A_STAT + 12'h001, 32'h0, {1'b1, 32'h0});
    // Events pending but masked: line stays low
    cmp_irq(1'b0);
    xact(1'b1, A_MSK, 32'hffff_ffff, 33'h0);
    xact(1'b0, A_MSK, 32'h0, 33'h7f);
    repeat (2) @(posedge sys_clk);
    cmp_irq(1'b1);
    // Clear every flag
    xact(1'b1, A_IST, 32'h0000_007f, 33'h0);
    repeat (3) @(posedge sys_clk);
    cmp_irq(1'b0);
    xact(1'b0, A_IST, 32'h0, 33'h0);
    // Warning toggles: one new event
    mon <= mon ^ 6'h01;
    repeat (5) @(posedge sys_clk);
    cmp_irq(1'b1);
    xact(1'b0, A_IST, 32'h0, 33'h02);
    // Masking drops the line, flag stays
    xact(1'b1, A_MSK, 32'h0, 33'h0);
    repeat (2) @(posedge sys_clk);
    cmp_irq(1'b0);
    xact(1'b0, A_IST, 32'h0, 33'h02);
    finish_test();
  end
endmodule
